// ==== inc/skx_pkg.sv ====
// Package for the skip, swap, xor and table-read execution block.
// Assumes one core clock and a core that presents operands with each instruction.
package skx_pkg;
  localparam int DATA_W = 8;
  localparam int PROG_W = 16;
  localparam int PAGE_W = 5;
  localparam int ADDR_W = PAGE_W + DATA_W;
  localparam int BIT_SEL_W = 3;
  localparam int NIB_LO_MSB = 3;
  localparam int NIB_HI_LSB = 4;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] WORKING_RST = 8'h00;
  localparam logic [DATA_W-1:0] TBL_HIGH_RST = 8'h00;
  localparam logic [PAGE_W-1:0] LAST_PAGE = 5'h1f;
  localparam logic [ADDR_W-1:0] PROG_ADDR_RST = 13'h0000;
  // Cycles taken by an instruction that skips
  localparam int SKIP_CYCLES = 2;

  typedef enum logic [3:0] {
    SKX_NOP = 4'h0,
    SKX_NIBBLE_SWAP_TO_WORKING = 4'h1,
    SKX_SKIP_IF_ZERO = 4'h2,
    SKX_COPY_THEN_SKIP_IF_NULL = 4'h3,
    SKX_SKIP_IF_BIT_CLEAR = 4'h4,
    SKX_TABLE_READ_PAGED = 4'h5,
    SKX_TABLE_READ_CURRENT_PAGE = 4'h6,
    SKX_TABLE_READ_LAST_PAGE = 4'h7,
    SKX_XOR_TO_WORKING = 4'h8,
    SKX_XOR_INTO_MEMORY = 4'h9,
    SKX_XOR_IMMEDIATE = 4'ha
  } skx_op_t;

  typedef enum logic [1:0] {
    SKX_IDLE = 2'b00,
    SKX_FETCH = 2'b01,
    SKX_DUMMY = 2'b10
  } skx_state_t;

  typedef struct packed {
    skx_op_t op;
    logic [BIT_SEL_W-1:0] bit_sel;
    logic [DATA_W-1:0] imm;
    logic [DATA_W-1:0] mem_byte;
  } skx_instr_t;

  typedef struct packed {
    logic [PAGE_W-1:0] pointer_high;
    logic [DATA_W-1:0] pointer_low;
    logic [PAGE_W-1:0] current_page;
  } skx_table_ptr_t;
endpackage

// ==== hw/skx_exec.sv ====
// Execution unit for nibble swap, conditional skips, table reads and xor forms.
// Assumes the core presents the addressed data byte with the instruction and
// that program memory holds the word while prog_re_q is high, taken at the edge that ends it.
// Functional notes
// - Swap data nibbles into working register only.
// - Skip next instruction when data byte zero.
// - Taken skip adds one dummy instruction cycle.
// - Copy byte to working; skip when zero.
// - Skip next instruction when selected bit clear.
// - Paged read: pointer high and low address.
// - Current page read uses current page and pointer low.
// - Last page read uses pointer low only.
// - Working gets working xor data byte.
// - Data byte gets working xor data byte.
// - Working gets working xor immediate operand.
`timescale 1ns/1ps
`default_nettype none
module skx_exec (
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire skx_pkg::skx_instr_t instr,
  output logic instr_ready,
  input wire skx_pkg::skx_table_ptr_t table_ptr,
  input wire logic [skx_pkg::PROG_W-1:0] prog_word,
  output logic prog_re_q,
  output logic [skx_pkg::ADDR_W-1:0] prog_addr_q,
  output logic mem_we_q,
  output logic [skx_pkg::DATA_W-1:0] mem_wdata_q,
  output logic [skx_pkg::DATA_W-1:0] working_q,
  output logic [skx_pkg::DATA_W-1:0] table_high_byte_q,
  output logic null_flag_q,
  output logic skip_q
);
  import skx_pkg::*;

  skx_state_t state_q;
  skx_state_t state_d;
  logic issue;
  logic skip_take;
  logic is_table;
  logic is_xor;
  logic [DATA_W-1:0] xor_operand;
  logic [DATA_W-1:0] xor_result;
  logic [ADDR_W-1:0] table_addr;

  assign instr_ready = (state_q == SKX_IDLE);
  assign issue = instr_valid && instr_ready;

  // Skip decision for the three skip forms
  always_comb begin
    skip_take = 1'b0;
    case (instr.op)
      SKX_SKIP_IF_ZERO: skip_take = (instr.mem_byte == BYTE_ZERO);
      SKX_COPY_THEN_SKIP_IF_NULL: skip_take = (instr.mem_byte == BYTE_ZERO);
      SKX_SKIP_IF_BIT_CLEAR: skip_take = ~instr.mem_byte[instr.bit_sel];
      default: skip_take = 1'b0;
    endcase
  end

  assign is_table = (instr.op == SKX_TABLE_READ_PAGED) || (instr.op == SKX_TABLE_READ_CURRENT_PAGE)
    || (instr.op == SKX_TABLE_READ_LAST_PAGE);
  assign is_xor = (instr.op == SKX_XOR_TO_WORKING) || (instr.op == SKX_XOR_INTO_MEMORY)
    || (instr.op == SKX_XOR_IMMEDIATE);
  assign xor_operand = (instr.op == SKX_XOR_IMMEDIATE) ? instr.imm : instr.mem_byte;
  assign xor_result = working_q ^ xor_operand;

  // Program address for the table reads
  always_comb begin
    case (instr.op)
      SKX_TABLE_READ_PAGED: table_addr = {table_ptr.pointer_high, table_ptr.pointer_low};
      SKX_TABLE_READ_CURRENT_PAGE: table_addr = {table_ptr.current_page, table_ptr.pointer_low};
      SKX_TABLE_READ_LAST_PAGE: table_addr = {LAST_PAGE, table_ptr.pointer_low};
      default: table_addr = PROG_ADDR_RST;
    endcase
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      SKX_IDLE: begin
        if (issue && skip_take) begin
          state_d = SKX_DUMMY;
        end else if (issue && is_table) begin
          state_d = SKX_FETCH;
        end
      end
      SKX_FETCH: state_d = SKX_IDLE;
      SKX_DUMMY: state_d = SKX_IDLE;
      default: state_d = SKX_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= SKX_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Dummy cycle marker, high while the skipped instruction is fetched
  always_ff @(posedge clk) begin
    if (rst) begin
      skip_q <= 1'b0;
    end else begin
      skip_q <= issue && skip_take;
    end
  end

  // Program memory request
  always_ff @(posedge clk) begin
    if (rst) begin
      prog_re_q <= 1'b0;
      prog_addr_q <= PROG_ADDR_RST;
    end else begin
      prog_re_q <= issue && is_table;
      if (issue && is_table) begin
        prog_addr_q <= table_addr;
      end
    end
  end

  // Working register
  always_ff @(posedge clk) begin
    if (rst) begin
      working_q <= WORKING_RST;
    end else if (issue) begin
      case (instr.op)
        SKX_NIBBLE_SWAP_TO_WORKING: working_q <= {instr.mem_byte[NIB_LO_MSB:0],
          instr.mem_byte[DATA_W-1:NIB_HI_LSB]};
        SKX_COPY_THEN_SKIP_IF_NULL: working_q <= instr.mem_byte;
        SKX_XOR_TO_WORKING: working_q <= xor_result;
        SKX_XOR_IMMEDIATE: working_q <= xor_result;
        default: working_q <= working_q;
      endcase
    end
  end

  // Result-null flag, touched only by the xor forms
  always_ff @(posedge clk) begin
    if (rst) begin
      null_flag_q <= 1'b0;
    end else if (issue && is_xor) begin
      null_flag_q <= (xor_result == BYTE_ZERO);
    end
  end

  // Data memory write: xor result now, table low byte after the fetch
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_we_q <= 1'b0;
      mem_wdata_q <= BYTE_ZERO;
    end else if (state_q == SKX_FETCH) begin
      mem_we_q <= 1'b1;
      mem_wdata_q <= prog_word[DATA_W-1:0];
    end else if (issue && (instr.op == SKX_XOR_INTO_MEMORY)) begin
      mem_we_q <= 1'b1;
      mem_wdata_q <= xor_result;
    end else begin
      mem_we_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      table_high_byte_q <= TBL_HIGH_RST;
    end else if (state_q == SKX_FETCH) begin
      table_high_byte_q <= prog_word[PROG_W-1:DATA_W];
    end
  end

  // Checks
  swap_result_a: assert property (@(posedge clk) disable iff (rst)
    issue && instr.op == SKX_NIBBLE_SWAP_TO_WORKING |=> working_q == {$past(instr.mem_byte[3:0]),
      $past(instr.mem_byte[7:4])} && !mem_we_q && null_flag_q == $past(null_flag_q))
    else $error("nibble swap result wrong");

  skip_zero_a: assert property (@(posedge clk) disable iff (rst)
    issue && instr.op == SKX_SKIP_IF_ZERO |=> skip_q == ($past(instr.mem_byte) == 8'h00))
    else $error("skip on zero byte wrong");

  dummy_cycle_a: assert property (@(posedge clk) disable iff (rst)
    issue && skip_take |=> !instr_ready ##1 instr_ready)
    else $error("skip did not take two cycles");

  copy_skip_a: assert property (@(posedge clk) disable iff (rst)
    issue && instr.op == SKX_COPY_THEN_SKIP_IF_NULL |=> working_q == $past(instr.mem_byte)
      && skip_q == (working_q == 8'h00))
    else $error("copy then skip wrong");

  bit_skip_a: assert property (@(posedge clk) disable iff (rst)
    issue && instr.op == SKX_SKIP_IF_BIT_CLEAR |=> skip_q != $past(instr.mem_byte[instr.bit_sel]))
    else $error("bit clear skip wrong");

  paged_addr_a: assert property (@(posedge clk) disable iff (rst)
    issue && instr.op == SKX_TABLE_READ_PAGED |=> prog_re_q
      && prog_addr_q == {$past(table_ptr.pointer_high), $past(table_ptr.pointer_low)})
    else $error("paged table address wrong");

  current_addr_a: assert property (@(posedge clk) disable iff (rst)
    issue && instr.op == SKX_TABLE_READ_CURRENT_PAGE |=> prog_re_q
      && prog_addr_q == {$past(table_ptr.current_page), $past(table_ptr.pointer_low)})
    else $error("current page table address wrong");

  last_page_a: assert property (@(posedge clk) disable iff (rst)
    issue && instr.op == SKX_TABLE_READ_LAST_PAGE |=> prog_addr_q[12:8] == 5'h1f
      ##1 mem_we_q && mem_wdata_q == $past(prog_word[7:0])
      && table_high_byte_q == $past(prog_word[15:8]))
    else $error("last page table read wrong");

  xor_working_a: assert property (@(posedge clk) disable iff (rst)
    issue && instr.op == SKX_XOR_TO_WORKING |=> working_q == ($past(working_q) ^ $past(instr.mem_byte))
      && !mem_we_q)
    else $error("xor to working wrong");

  xor_memory_a: assert property (@(posedge clk) disable iff (rst)
    issue && instr.op == SKX_XOR_INTO_MEMORY |=> mem_we_q
      && mem_wdata_q == ($past(working_q) ^ $past(instr.mem_byte)) && $stable(working_q))
    else $error("xor into memory wrong");

  xor_imm_a: assert property (@(posedge clk) disable iff (rst)
    issue && instr.op == SKX_XOR_IMMEDIATE |=> working_q == ($past(working_q) ^ $past(instr.imm)))
    else $error("xor immediate wrong");

  null_flag_a: assert property (@(posedge clk) disable iff (rst)
    issue && instr.op == SKX_XOR_TO_WORKING |=> null_flag_q == (working_q == 8'h00))
    else $error("null flag wrong");

  // Flag and side effects of the xor forms
  null_memory_a: assert property (@(posedge clk) disable iff (rst)
    issue && instr.op == SKX_XOR_INTO_MEMORY |=> null_flag_q == (mem_wdata_q == BYTE_ZERO))
    else $error("null flag after xor into memory wrong");

  null_immediate_a: assert property (@(posedge clk) disable iff (rst)
    issue && instr.op == SKX_XOR_IMMEDIATE |=> null_flag_q == (working_q == BYTE_ZERO))
    else $error("null flag after xor immediate wrong");

  xor_no_write_a: assert property (@(posedge clk) disable iff (rst)
    issue && (instr.op == SKX_XOR_TO_WORKING || instr.op == SKX_XOR_IMMEDIATE) |=> !mem_we_q
      && $stable(table_high_byte_q))
    else $error("xor to working wrote memory");

  null_hold_a: assert property (@(posedge clk) disable iff (rst)
    issue && !is_xor |=> $stable(null_flag_q))
    else $error("null flag changed by a non xor instruction");

  // Skip family and the dummy cycle
  skip_flags_a: assert property (@(posedge clk) disable iff (rst)
    issue && (instr.op == SKX_SKIP_IF_ZERO || instr.op == SKX_SKIP_IF_BIT_CLEAR) |=> $stable(working_q)
      && $stable(null_flag_q) && !mem_we_q)
    else $error("skip test changed state");

  copy_flags_a: assert property (@(posedge clk) disable iff (rst)
    issue && instr.op == SKX_COPY_THEN_SKIP_IF_NULL |=> $stable(null_flag_q) && !mem_we_q)
    else $error("copy then skip touched flag or memory");

  no_skip_a: assert property (@(posedge clk) disable iff (rst)
    issue && !skip_take |=> !skip_q)
    else $error("skip marker without taken skip");

  skip_pulse_a: assert property (@(posedge clk) disable iff (rst)
    skip_q |-> state_q == SKX_DUMMY && !instr_ready ##1 !skip_q)
    else $error("dummy cycle marker wrong");

  single_cycle_a: assert property (@(posedge clk) disable iff (rst)
    issue && !skip_take && !is_table |=> instr_ready && !skip_q && !prog_re_q)
    else $error("plain instruction did not take one cycle");

  idle_hold_a: assert property (@(posedge clk) disable iff (rst)
    !issue |=> $stable(working_q) && $stable(null_flag_q))
    else $error("state changed without an issued instruction");

  // Table reads
  table_data_a: assert property (@(posedge clk) disable iff (rst)
    issue && (instr.op == SKX_TABLE_READ_PAGED || instr.op == SKX_TABLE_READ_CURRENT_PAGE) |=> !instr_ready
      ##1 mem_we_q && mem_wdata_q == $past(prog_word[7:0]) && table_high_byte_q == $past(prog_word[15:8]))
    else $error("table read data wrong");

  table_flags_a: assert property (@(posedge clk) disable iff (rst)
    issue && is_table |=> $stable(null_flag_q) && $stable(working_q) && !skip_q
      ##1 $stable(null_flag_q) && $stable(working_q))
    else $error("table read changed working register or flag");

  fetch_pulse_a: assert property (@(posedge clk) disable iff (rst)
    prog_re_q |-> state_q == SKX_FETCH ##1 !prog_re_q && mem_we_q)
    else $error("program read request wrong");

  fetch_state_a: assert property (@(posedge clk) disable iff (rst)
    prog_re_q == (state_q == SKX_FETCH))
    else $error("program read request outside the fetch cycle");

  addr_hold_a: assert property (@(posedge clk) disable iff (rst)
    !(issue && is_table) |=> $stable(prog_addr_q))
    else $error("program address changed without a table read");

  write_source_a: assert property (@(posedge clk) disable iff (rst)
    mem_we_q |-> $past(state_q) == SKX_FETCH || $past(issue && instr.op == SKX_XOR_INTO_MEMORY))
    else $error("data memory write without cause");

  table_high_hold_a: assert property (@(posedge clk) disable iff (rst)
    state_q != SKX_FETCH |=> $stable(table_high_byte_q))
    else $error("table high byte changed outside a table read");
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the skip, swap, xor and table-read execution unit.
// Assumes skx_pkg is compiled first; the bench plays core, data and program memory.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import skx_pkg::*;
  logic clk, rst, instr_valid, instr_ready, prog_re_q, mem_we_q, null_flag_q, skip_q;
  skx_instr_t instr;
  skx_table_ptr_t table_ptr;
  logic [PROG_W-1:0] prog_word;
  logic [ADDR_W-1:0] prog_addr_q;
  logic [DATA_W-1:0] mem_wdata_q, working_q, table_high_byte_q;
  int fails, checks_done, w, th, z;
  skx_instr_t ins;

  skx_exec dut_u (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
    .table_ptr(table_ptr), .prog_word(prog_word), .prog_re_q(prog_re_q), .prog_addr_q(prog_addr_q),
    .mem_we_q(mem_we_q), .mem_wdata_q(mem_wdata_q), .working_q(working_q),
    .table_high_byte_q(table_high_byte_q), .null_flag_q(null_flag_q), .skip_q(skip_q));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input int e, input logic [15:0] g);
    checks_done++;
    if (g !== 16'(e)) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, 16'(e), g);
    end
  endtask

  task automatic do_reset;
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    w = WORKING_RST;
    th = TBL_HIGH_RST;
    z = 0;
    chk("rst_out", 0, {prog_re_q, mem_we_q, null_flag_q, skip_q, working_q | table_high_byte_q | mem_wdata_q});
    chk("rst_addr", PROG_ADDR_RST, prog_addr_q);
    chk("rst_ready", 1, instr_ready);
  endtask

  // Model one instruction, issue it, then compare every result cycle
  task automatic run(input skx_instr_t i);
    int r, n;
    logic tk, tbr, wr;
    logic [ADDR_W-1:0] a;
    logic [PROG_W-1:0] wd;
    skx_table_ptr_t p;
    wd = PROG_W'($urandom);
    p = skx_table_ptr_t'(18'($urandom));
    tk = 1'b0;
    tbr = 1'b0;
    wr = 1'b0;
    r = 0;
    a = '0;
    case (i.op)
      SKX_NIBBLE_SWAP_TO_WORKING: w = {i.mem_byte[3:0], i.mem_byte[7:4]};
      SKX_SKIP_IF_ZERO: tk = (i.mem_byte == 0);
      SKX_COPY_THEN_SKIP_IF_NULL: begin
        w = i.mem_byte;
        tk = (w == 0);
      end
      SKX_SKIP_IF_BIT_CLEAR: tk = !i.mem_byte[i.bit_sel];
      SKX_TABLE_READ_PAGED: {tbr, a} = {1'b1, p.pointer_high, p.pointer_low};
      SKX_TABLE_READ_CURRENT_PAGE: {tbr, a} = {1'b1, p.current_page, p.pointer_low};
      SKX_TABLE_READ_LAST_PAGE: {tbr, a} = {1'b1, LAST_PAGE, p.pointer_low};
      SKX_XOR_TO_WORKING: begin
        w = w ^ i.mem_byte;
        z = (w == 0);
      end
      SKX_XOR_INTO_MEMORY: begin
        r = w ^ i.mem_byte;
        wr = 1'b1;
        z = (r == 0);
      end
      SKX_XOR_IMMEDIATE: begin
        w = w ^ i.imm;
        z = (w == 0);
      end
      default: ;
    endcase
    n = 0;
    while (instr_ready !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 10) begin
        fails++;
        test_done();
      end
    end
    @(posedge clk) instr_valid <= 1'b1;
    instr <= i;
    table_ptr <= p;
    // A refused cycle keeps offering the same instruction
    @(posedge clk) instr_valid <= tk | tbr;
    prog_word <= wd;
    #1;
    chk("working", w, working_q);
    chk("null", z, null_flag_q);
    chk("skip", tk, skip_q);
    chk("ready", !(tk | tbr), instr_ready);
    chk("mem_we", wr, mem_we_q);
    if (wr) chk("wdata", r, mem_wdata_q);
    chk("prog_re", tbr, prog_re_q);
    if (tbr) chk("prog_addr", a, prog_addr_q);
    chk("tbl_high", th, table_high_byte_q);
    if (tk | tbr) begin
      @(posedge clk) instr_valid <= 1'b0;
      prog_word <= ~wd;
      #1;
      if (tbr) th = wd[15:8];
      chk("skip_end", 0, skip_q);
      chk("re_end", 0, prog_re_q);
      chk("we_tbl", tbr, mem_we_q);
      if (tbr) chk("wdata_tbl", wd[7:0], mem_wdata_q);
      chk("tbl_high2", th, table_high_byte_q);
      chk("working2", w, working_q);
      chk("null2", z, null_flag_q);
    end
  endtask

  task automatic rand_ops(input int cnt);
    repeat (cnt) begin
      ins = skx_instr_t'(23'($urandom));
      ins.op = skx_op_t'($urandom_range(0, 10));
      case ($urandom_range(0, 3))
        0: ins.mem_byte = 8'h00;
        1: {ins.mem_byte, ins.imm} = {8'(w), 8'(w)};
        default: ;
      endcase
      run(ins);
    end
  endtask

  initial begin
    rst = 1'b1;
    instr_valid = 1'b0;
    instr = '0;
    table_ptr = '0;
    prog_word = '0;
    fails = 0;
    checks_done = 0;
    void'($urandom(32'hb4ad));
    do_reset();
    // Every operation with a zero byte and with a non-zero byte
    for (int k = 0; k <= 10; k++) begin
      for (int v = 0; v < 2; v++) begin
        ins = skx_instr_t'(23'($urandom));
        ins.op = skx_op_t'(k);
        ins.mem_byte = v ? 8'h5a : 8'h00;
        run(ins);
      end
    end
    rand_ops(300);
    do_reset();
    rand_ops(50);
    test_done();
  end
endmodule
`default_nettype wire
